/* File: hdl/pwm_output.sv */
// 8-bit prescaled pulse-width modulator with two selectable shared pins.
// Assumes control inputs are synchronous to sys_clk (stands for the oscillator).
//
// Summary of operation
// RL1: 8-bit duty; oscillator or oscillator/2 count source.
// RL2: Pin select bit routes output to pin a or b.
// RL3: Period is 255 times (n+1) count ticks.
// RL4: High time is m ticks of 255.
// RL5: Enable initialises circuit; periods start high. Code: with m zero the output stays low.
// RL6: New n and m take effect next period.
// RL7: Low interval precedes first period after enable.
// RL8: Unselected pin keeps its ordinary port function.
// RL9: Clearing enable stops counters, holds output low.
`timescale 1ns/1ps
`default_nettype none
module pwm_output #(
  parameter int WIDTH = pwm_pkg::DATA_W
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic             pin_select_b,
  input  wire logic             count_source,
  input  wire logic [WIDTH-1:0] prescale_n,
  input  wire logic [WIDTH-1:0] duty_m,
  input  wire logic             port_a_out,
  input  wire logic             port_a_oe,
  input  wire logic             port_b_out,
  input  wire logic             port_b_oe,
  output logic                  shared_port_pin_a_out,
  output logic                  shared_port_pin_a_oe,
  output logic                  shared_port_pin_b_out,
  output logic                  shared_port_pin_b_oe,
  output logic                  pwm_level,
  output logic                  running
);

  pwm_pkg::pwm_state_t state;
  pwm_pkg::pwm_state_t next_state;
  logic [WIDTH-1:0]    n_cur;
  logic [WIDTH-1:0]    next_n_cur;
  logic [WIDTH-1:0]    m_cur;
  logic [WIDTH-1:0]    next_m_cur;
  logic [WIDTH-1:0]    slot;
  logic [WIDTH-1:0]    next_slot;
  logic [WIDTH:0]      lead_cnt;
  logic [WIDTH:0]      next_lead_cnt;
  logic [WIDTH:0]      lead_len;
  logic                next_pwm_level;
  logic                tick;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  tick_divider #(
    .WIDTH (WIDTH)
  ) u_div (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .run       (state == pwm_pkg::ST_RUN),
    .half_rate (count_source),
    .limit     (n_cur),
    .tick      (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    // Setting 1: n+1 clocks; setting 0: half that, rounded up
    lead_len = count_source ? ({1'b0, prescale_n} + 1'b1)
                            : (({1'b0, prescale_n} + 2'd2) >> 1);  // RL7
    next_state    = state;
    next_n_cur    = n_cur;
    next_m_cur    = m_cur;
    next_slot     = slot;
    next_lead_cnt = lead_cnt;
    case (state)
      pwm_pkg::ST_IDLE: begin
        if (enable) begin
          next_state    = pwm_pkg::ST_LEAD;              // RL5
          next_lead_cnt = '0;
        end
      end
      pwm_pkg::ST_LEAD: begin
        next_lead_cnt = lead_cnt + 1'b1;                 // RL7
        if (lead_cnt + 1'b1 >= lead_len) begin
          next_state = pwm_pkg::ST_RUN;
          next_slot  = '0;
          next_n_cur = prescale_n;
          next_m_cur = duty_m;
        end
      end
      pwm_pkg::ST_RUN: begin
        if (tick) begin
          if (slot == pwm_pkg::SLOTS_LAST) begin         // RL3
            next_slot  = '0;
            next_n_cur = prescale_n;                     // RL6
            next_m_cur = duty_m;                         // RL6
          end else begin
            next_slot = slot + 1'b1;
          end
        end
      end
      default: next_state = pwm_pkg::ST_IDLE;
    endcase
    if (!enable) begin
      next_state = pwm_pkg::ST_IDLE;                     // RL9
    end
    // High while slot below m, so each period starts high unless m is zero
    next_pwm_level = (next_state == pwm_pkg::ST_RUN) && (next_slot < next_m_cur);  // RL4
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= pwm_pkg::ST_IDLE;
      n_cur     <= pwm_pkg::RESET_VALUE;
      m_cur     <= pwm_pkg::RESET_VALUE;
      slot      <= pwm_pkg::RESET_VALUE;
      lead_cnt  <= '0;
      pwm_level <= 1'b0;
    end else begin
      state     <= next_state;
      n_cur     <= next_n_cur;
      m_cur     <= next_m_cur;
      slot      <= next_slot;
      lead_cnt  <= next_lead_cnt;
      pwm_level <= next_pwm_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sharing

  always_comb begin
    running               = (state == pwm_pkg::ST_RUN);
    shared_port_pin_a_out = pin_select_b ? port_a_out : pwm_level;  // RL2 RL8
    shared_port_pin_a_oe  = pin_select_b ? port_a_oe  : 1'b1;       // RL8
    shared_port_pin_b_out = pin_select_b ? pwm_level  : port_b_out; // RL2 RL8
    shared_port_pin_b_oe  = pin_select_b ? 1'b1       : port_b_oe;  // RL8
  end

endmodule : pwm_output
`default_nettype wire

/* File: inc/pwm_pkg.sv */
// Shared constants for the 8-bit prescaled modulator.
// Assumes a single system clock that stands in for the oscillator input.
package pwm_pkg;

  localparam int          DATA_W         = 8;
  localparam logic [7:0]  SLOTS_LAST     = 8'hFE;  // 255 ticks per period: 0..254
  localparam logic [7:0]  RESET_VALUE    = 8'h00;
  localparam int          SEL_PIN_B_BIT  = 2;      // Control bit position of pin choice
  localparam int          ENABLE_BIT     = 0;      // Control bit position of enable
  localparam real         CLK_PERIOD_NS  = 8.0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN  = 2'b10
  } pwm_state_t;

endpackage : pwm_pkg

/* File: hdl/tick_divider.sv */
// Count-source and prescaler divider producing a one-cycle tick enable.
// Assumes run is low for at least one cycle to restart the count phase.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic             half_rate,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  tick
);

  logic             phase;
  logic             next_phase;
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic             src_en;

  always_comb begin
    src_en     = run && (!half_rate || phase);     // RL1
    next_phase = run ? ~phase : 1'b0;
    next_cnt   = cnt;
    tick       = src_en && (cnt == limit);         // RL3
    if (!run) begin
      next_cnt = '0;
    end else if (src_en) begin
      next_cnt = (cnt == limit) ? '0 : cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 1'b0;
      cnt   <= '0;
    end else begin
      phase <= next_phase;
      cnt   <= next_cnt;
    end
  end

endmodule : tick_divider
`default_nettype wire

/* File: verif/pwm_output_sva.sv */
// Port checker for the prescaled modulator.
// Assumes binding onto pwm_output with one sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_chk (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       enable,
  input wire logic       pin_select_b,
  input wire logic [7:0] duty_m,
  input wire logic       port_a_out,
  input wire logic       port_a_oe,
  input wire logic       port_b_out,
  input wire logic       port_b_oe,
  input wire logic       shared_port_pin_a_out,
  input wire logic       shared_port_pin_a_oe,
  input wire logic       shared_port_pin_b_out,
  input wire logic       shared_port_pin_b_oe,
  input wire logic       pwm_level,
  input wire logic       running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_pin_a_route: assert property (!pin_select_b |-> shared_port_pin_a_oe
    && shared_port_pin_a_out == pwm_level) else $error("pin a route");
  a_pin_b_route: assert property (pin_select_b |-> shared_port_pin_b_oe
    && shared_port_pin_b_out == pwm_level) else $error("pin b route");
  a_port_a_pass: assert property (pin_select_b |-> shared_port_pin_a_oe == port_a_oe
    && shared_port_pin_a_out == port_a_out) else $error("pin a port");
  a_port_b_pass: assert property (!pin_select_b |-> shared_port_pin_b_oe == port_b_oe
    && shared_port_pin_b_out == port_b_out) else $error("pin b port");
  a_disable_low: assert property (!enable |=> !pwm_level && !running)
    else $error("not idle");
  a_lead_low: assert property ($rose(enable) |=> !pwm_level && !running)
    else $error("no lead");
  a_lead_wait: assert property ($rose(running) |-> $past(enable, 2))
    else $error("lead short");
  a_start_high: assert property ($rose(running) && duty_m != 8'h00 |-> pwm_level)
    else $error("start low");
  c_run: cover property ($rose(running));
  c_pin_b: cover property (pin_select_b && pwm_level);
  c_wrap: cover property (running && $rose(pwm_level));
endmodule : pwm_output_chk
`default_nettype wire

/* File: verif/pwm_output_bench.sv */
// Self-checking bench: lead, period, high time, update timing.
// Assumes 125 MHz sys_clk; the checker is bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_bench;
  logic       sys_clk = 0, reset_n = 0, enable = 0, sel = 0, src = 0;
  logic [7:0] n = 8'h00, m = 8'h01;
  logic       pa = 0, pao = 0, pb = 0, pbo = 0, lvl, run, was_run = 0, was_lvl = 0;
  logic       was_en = 0;
  int         fail_count = 0, n_compared = 0, seed = 77, cnt = 0, hi = 0, cyc = 0, q[$];
  initial forever #4 sys_clk = ~sys_clk;
  pwm_output i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .enable(enable),
    .pin_select_b(sel), .count_source(src), .prescale_n(n), .duty_m(m),
    .port_a_out(pa), .port_a_oe(pao), .port_b_out(pb), .port_b_oe(pbo),
    .shared_port_pin_a_out(), .shared_port_pin_a_oe(), .shared_port_pin_b_out(),
    .shared_port_pin_b_oe(), .pwm_level(lvl), .running(run));
  task check(input string what, input logic [31:0] seen, input logic [31:0] expected);
    n_compared++;
    if (seen !== expected) begin
      fail_count++;
      $display("unexpected %s: expected %0d seen %0d", what, expected, seen);
    end
  endtask : check
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task push_period;
    int t;
    t = (n + 1) * (src ? 2 : 1);
    q.push_back(m * t);
    q.push_back(255 * t);
  endtask : push_period
  task run_case(input int k);
    sel = k[0];
    src = k[1];
    n = 8'({$random(seed)} % 4);
    m = 8'({$random(seed)} % 254 + 1);
    // Lead cycles plus the enable cycle and the first cycle in the run state
    q.push_back((src ? n + 1 : (n + 2) / 2) + 2);
    push_period();
    enable = 1;
    while (!run) @(negedge sys_clk);
    @(posedge sys_clk);
    #1;
    n = 8'({$random(seed)} % 4);
    m = 8'({$random(seed)} % 254 + 1);
    push_period();
    wait (q.size() == 0);
    @(posedge sys_clk);
    #1 enable = 0;
    repeat (3) @(posedge sys_clk);
    #1 $display("case %0d done", k);
  endtask : run_case
  // Extreme duties: zero never goes high, 255 stays high across period wraps
  task run_flat(input logic [7:0] mv);
    sel = mv[0];
    src = 0;
    n = 8'h00;
    m = mv;
    q.push_back((n + 2) / 2 + 2);
    q.push_back(mv == 8'h00 ? 0 : 599);
    enable = 1;
    while (!run) @(negedge sys_clk);
    repeat (600) @(posedge sys_clk);
    #1 enable = 0;
    repeat (3) @(posedge sys_clk);
    #1 $display("flat %0d done", mv);
  endtask : run_flat
  always @(posedge sys_clk) begin
    #1 {pa, pao, pb, pbo} = 4'($random(seed));
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end
  // Period results are timed at the falling edge, where outputs have settled
  always @(negedge sys_clk) begin
    if (!enable && was_en && q.size() > 0) begin
      check("flat high time", hi, q.pop_front());
    end
    if (!enable) cnt = 0;
    else begin
      cnt++;
      hi += int'(lvl);
      if (run && !was_run) begin
        check("lead", cnt, q.pop_front());
        cnt = 0;
        hi = 0;
      end else if (lvl && !was_lvl) begin
        check("high time", hi, q.pop_front());
        check("period", cnt, q.pop_front());
        cnt = 0;
        hi = 0;
      end
    end
    was_run = run;
    was_lvl = lvl;
    was_en = enable;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 reset_n = 1;
    for (int k = 0; k < 8; k++) run_case(k);
    run_flat(8'h00);
    run_flat(8'hFF);
    summarize();
  end
endmodule : pwm_output_bench
bind pwm_output pwm_output_chk i_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .enable(enable), .pin_select_b(pin_select_b), .duty_m(duty_m),
  .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_out(port_b_out),
  .port_b_oe(port_b_oe), .shared_port_pin_a_out(shared_port_pin_a_out),
  .shared_port_pin_a_oe(shared_port_pin_a_oe), .shared_port_pin_b_out(shared_port_pin_b_out),
  .shared_port_pin_b_oe(shared_port_pin_b_oe), .pwm_level(pwm_level), .running(running));
`default_nettype wire
